/* logic/supply_startup_line_supervisor.sv */
//
// Notes on behaviour
// - Full startup current only above inhibit level, reduced current below it.
// - At start threshold, both startup sources off and controller enabled.
// - Below stop threshold, stages off and both startup sources on.
// - Power saving: source on below standby level, off above it.
// - Power saving: a source charges only while its pin is above 30 V.
// - Leaving power saving enables both sources; restart at start threshold.
// - Supply overvoltage while flyback runs latches the controller off.
// - Fault disables controller; restart at start threshold once faults clear.
// - Flyback enabled only with line above brown-out start and supply started.
// - Line rising past brown-out start enables startup sources at once.
// - Line below brown-out stop runs 54 ms timer, then stages off below 30 V.
// - Range flag powers up as low line.
// - Line above select level over 300 us switches to high line.
// - After high to low switch, inhibit low-to-high timer until brown-out stop.
// - High line: 54 ms below select level returns to low line.
// - High line cuts maximum PFC on time by three.
// - Range from peak line level selects one of two feedforward gains.
// - Line absent: controller off, sink supply to stop level, then sources on.
// - After the first discharge, low current state at stop level.
// - PFC disabled means its feedback divider is disconnected.
`timescale 1ns/1ps
`default_nettype none
module supply_startup_line_supervisor #(
  parameter int unsigned BROWNOUT_CYC    = supervisor_pkg::BROWNOUT_CYC,
  parameter int unsigned LOW_TO_HIGH_CYC = supervisor_pkg::LOW_TO_HIGH_CYC,
  parameter int unsigned HIGH_TO_LOW_CYC = supervisor_pkg::HIGH_TO_LOW_CYC
) (
  // Clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_srst,
  // Comparator results
  input  wire supervisor_pkg::cmp_t        i_cmp,
  // Controls
  output var  supervisor_pkg::supply_ctl_t o_supply,
  output var  supervisor_pkg::stage_ctl_t  o_stage,
  output var  supervisor_pkg::range_ctl_t  o_range
);

  localparam int unsigned CW = supervisor_pkg::TIMER_W;

  function automatic logic timer_done(input logic [CW-1:0] cnt,
                                      input logic [CW-1:0] last);
    timer_done = (cnt == last);
  endfunction

  logic [$bits(supervisor_pkg::cmp_t)-1:0] cmp_bits;
  supervisor_pkg::cmp_t                    cmp;
  supervisor_pkg::state_t                  state;
  supervisor_pkg::state_t                  next_state;
  supervisor_pkg::supply_ctl_t             next_supply;
  supervisor_pkg::stage_ctl_t              next_stage;
  supervisor_pkg::range_ctl_t              next_range;
  logic                                    bo_ok;
  logic                                    bo_expired;
  logic [CW-1:0]                           bo_cnt;
  logic                                    line_start_prev;
  logic                                    high_line;
  logic                                    lh_inhibit;
  logic [CW-1:0]                           lh_cnt;
  logic [CW-1:0]                           hl_cnt;
  logic                                    discharge_seen;

  level_sync #(
    .WIDTH ($bits(supervisor_pkg::cmp_t))
  ) u_sync (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_async (i_cmp),
    .o_sync  (cmp_bits)
  );

  assign cmp = supervisor_pkg::cmp_t'(cmp_bits);

  // Decoded conditions
  wire line_start_rise = cmp.line_above_bo_start && !line_start_prev;
  wire fault_latch     = cmp.fault_latching
                         || (o_stage.flyback_enable && cmp.supply_above_ovp);
  wire start_ok        = cmp.supply_above_start && !cmp.fault_auto;
  wire in_charge       = (state == supervisor_pkg::ST_CHARGE);
  wire in_run          = (state == supervisor_pkg::ST_RUN);
  wire in_save         = (state == supervisor_pkg::ST_SAVE);
  wire in_disch        = (state == supervisor_pkg::ST_DISCH);
  wire run_en          = in_run && bo_ok;
  wire save_need       = in_save && !cmp.supply_above_standby;
  wire bo_last         = timer_done(bo_cnt, CW'(BROWNOUT_CYC - 1));
  wire lh_run          = !high_line && !lh_inhibit && cmp.line_above_line_select;
  wire hl_run          = high_line && !cmp.line_above_line_select;
  wire lh_last         = timer_done(lh_cnt, CW'(LOW_TO_HIGH_CYC));
  wire hl_last         = timer_done(hl_cnt, CW'(HIGH_TO_LOW_CYC - 1));
  wire to_high         = lh_run && lh_last;
  wire to_low          = hl_run && hl_last;

  always_comb
  begin
    next_state = state;
    unique case (state)
      supervisor_pkg::ST_CHARGE:
      begin
        if (cmp.line_absent)
          next_state = supervisor_pkg::ST_SINK;
        else if (cmp.fault_latching)
          next_state = supervisor_pkg::ST_LATCH;
        else if (start_ok)
          next_state = supervisor_pkg::ST_RUN;
      end
      supervisor_pkg::ST_RUN:
      begin
        if (cmp.line_absent)
          next_state = supervisor_pkg::ST_SINK;
        else if (fault_latch)
          next_state = supervisor_pkg::ST_LATCH;
        else if (cmp.fault_auto)
          next_state = supervisor_pkg::ST_CHARGE;
        else if (!cmp.supply_above_stop)
          next_state = supervisor_pkg::ST_CHARGE;
        else if (line_start_rise && !bo_ok)
          next_state = supervisor_pkg::ST_CHARGE;
        else if (cmp.power_saving_mode)
          next_state = supervisor_pkg::ST_SAVE;
      end
      supervisor_pkg::ST_SAVE:
      begin
        if (cmp.line_absent)
          next_state = supervisor_pkg::ST_SINK;
        else if (!cmp.power_saving_mode)
          next_state = supervisor_pkg::ST_CHARGE;
      end
      supervisor_pkg::ST_SINK:
      begin
        if (!cmp.supply_above_stop)
          next_state = supervisor_pkg::ST_DISCH;
      end
      supervisor_pkg::ST_DISCH:
      begin
        if (discharge_seen && !cmp.supply_above_stop)
          next_state = supervisor_pkg::ST_LOWCUR;
        else if (line_start_rise && !cmp.line_absent)
          next_state = supervisor_pkg::ST_CHARGE;
      end
      supervisor_pkg::ST_LOWCUR:
      begin
        if (line_start_rise && !cmp.line_absent)
          next_state = supervisor_pkg::ST_CHARGE;
      end
      supervisor_pkg::ST_LATCH:
      begin
        next_state = supervisor_pkg::ST_LATCH;
      end
      default:
      begin
        next_state = supervisor_pkg::ST_CHARGE;
      end
    endcase
  end

  // Output decode
  always_comb
  begin
    next_supply.hv_src_on   = in_charge || in_disch
                              || (save_need && cmp.hv_pin_above_ps);
    next_supply.line_src_on = in_charge || in_disch
                              || (save_need && cmp.line_pin_above_ps);
    next_supply.src_full    = cmp.supply_above_inhibit;
    next_supply.sink_on     = (state == supervisor_pkg::ST_SINK);
    next_supply.low_current = (state == supervisor_pkg::ST_LOWCUR);
    next_stage.pfc_enable      = run_en;
    next_stage.flyback_enable  = run_en;
    next_stage.divider_connect = run_en;
    next_stage.latched         = (state == supervisor_pkg::ST_LATCH);
    next_range.high_line    = high_line;
    next_range.ff_gain_high = high_line;
    next_range.ontime_div   = high_line ? supervisor_pkg::ONTIME_DIV_HIGH
                                        : supervisor_pkg::ONTIME_DIV_LOW;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      state          <= supervisor_pkg::ST_CHARGE;
      discharge_seen <= 1'b0;
      o_supply       <= '0;
      o_stage        <= '0;
      o_range        <= '0;
    end
    else
    begin
      state          <= next_state;
      discharge_seen <= in_disch && (discharge_seen || cmp.supply_above_stop);
      o_supply       <= next_supply;
      o_stage        <= next_stage;
      o_range        <= next_range;
    end
  end

  // Brown-out timer and drive permission
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      line_start_prev <= 1'b0;
      bo_ok           <= 1'b0;
      bo_cnt          <= '0;
      bo_expired      <= 1'b0;
    end
    else
    begin
      line_start_prev <= cmp.line_above_bo_start;
      if (cmp.line_above_bo_stop)
      begin
        bo_cnt     <= '0;
        bo_expired <= 1'b0;
      end
      else if (!bo_expired)
      begin
        bo_cnt     <= bo_cnt + CW'(1);
        bo_expired <= bo_last;
      end
      if (line_start_rise)
        bo_ok <= 1'b1;
      else if (bo_expired && !cmp.line_above_drive_disable)
        bo_ok <= 1'b0;
    end
  end

  // Line range detector
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      high_line  <= supervisor_pkg::HIGH_LINE_RESET;
      lh_inhibit <= 1'b0;
      lh_cnt     <= '0;
      hl_cnt     <= '0;
    end
    else
    begin
      lh_cnt <= lh_run && !lh_last ? lh_cnt + CW'(1) : '0;
      hl_cnt <= hl_run && !hl_last ? hl_cnt + CW'(1) : '0;
      if (to_high)
        high_line <= 1'b1;
      else if (to_low)
        high_line <= 1'b0;
      if (to_low)
        lh_inhibit <= 1'b1;
      else if (!cmp.line_above_bo_stop)
        lh_inhibit <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  sequence s_both_src;
    o_supply.hv_src_on && o_supply.line_src_on;
  endsequence

  sequence s_stages_off;
    !o_stage.pfc_enable && !o_stage.flyback_enable;
  endsequence

  property p_reduced_current;
    !cmp.supply_above_inhibit |=> !o_supply.src_full;
  endproperty
  a_reduced_current: assert property (p_reduced_current)
    else $error("full startup current below inhibit level");

  property p_start_run;
    in_charge && start_ok && !cmp.line_absent && !cmp.fault_latching
      |=> in_run ##1 (!o_supply.hv_src_on && !o_supply.line_src_on);
  endproperty
  a_start_run: assert property (p_start_run)
    else $error("start threshold did not start controller");

  property p_stop_recharge;
    in_run && !cmp.supply_above_stop && !cmp.line_absent && !fault_latch
      |=> in_charge ##1 (s_both_src and s_stages_off);
  endproperty
  a_stop_recharge: assert property (p_stop_recharge)
    else $error("stop threshold did not recharge supply");

  property p_save_regulate;
    in_save && cmp.supply_above_standby
      |=> !o_supply.hv_src_on && !o_supply.line_src_on;
  endproperty
  a_save_regulate: assert property (p_save_regulate)
    else $error("source on above standby level");

  property p_save_pin;
    in_save && !cmp.hv_pin_above_ps |=> !o_supply.hv_src_on;
  endproperty
  a_save_pin: assert property (p_save_pin)
    else $error("source charging from low pin voltage");

  property p_save_exit;
    in_save && !cmp.power_saving_mode && !cmp.line_absent |=> ##1 s_both_src;
  endproperty
  a_save_exit: assert property (p_save_exit)
    else $error("sources not on after power saving exit");

  property p_ovp_latch;
    in_run && o_stage.flyback_enable && cmp.supply_above_ovp && !cmp.line_absent
      |=> ##1 o_stage.latched [*3] ##0 !o_stage.flyback_enable;
  endproperty
  a_ovp_latch: assert property (p_ovp_latch)
    else $error("overvoltage did not latch controller");

  property p_fault_off;
    in_run && cmp.fault_auto && !cmp.line_absent && !fault_latch
      |=> ##1 s_stages_off;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("fault did not disable controller");

  property p_flyback_cond;
    o_stage.flyback_enable |-> $past(bo_ok) && $past(in_run);
  endproperty
  a_flyback_cond: assert property (p_flyback_cond)
    else $error("flyback enabled without line or supply");

  property p_high_entry;
    $rose(high_line) |-> $past(lh_cnt) == CW'(LOW_TO_HIGH_CYC) && !$past(lh_inhibit);
  endproperty
  a_high_entry: assert property (p_high_entry)
    else $error("high line entered early");

  property p_sink;
    state == supervisor_pkg::ST_SINK |=> o_supply.sink_on and s_stages_off;
  endproperty
  a_sink: assert property (p_sink)
    else $error("line absence did not sink supply");

  property p_divider;
    !o_stage.pfc_enable |-> !o_stage.divider_connect;
  endproperty
  a_divider: assert property (p_divider)
    else $error("divider connected with PFC disabled");

endmodule // supply_startup_line_supervisor
`default_nettype wire

/* logic/supervisor_pkg.sv */
`default_nettype none
package supervisor_pkg;

  // Clock rate and nominal durations
  localparam int unsigned CLOCK_MHZ          = 20;
  localparam int unsigned BROWNOUT_TIMER_US  = 54000;
  localparam int unsigned HIGH_TO_LOW_US     = 54000;
  localparam int unsigned LOW_TO_HIGH_US     = 300;
  localparam int unsigned BROWNOUT_CYC       = BROWNOUT_TIMER_US * CLOCK_MHZ;
  localparam int unsigned HIGH_TO_LOW_CYC    = HIGH_TO_LOW_US * CLOCK_MHZ;
  localparam int unsigned LOW_TO_HIGH_CYC    = LOW_TO_HIGH_US * CLOCK_MHZ;
  localparam int unsigned TIMER_W            = 21;
  localparam int unsigned SYNC_STAGES        = 2;

  // Line range encodings and reset values
  localparam logic [1:0] ONTIME_DIV_LOW      = 2'h1;
  localparam logic [1:0] ONTIME_DIV_HIGH     = 2'h3;
  localparam logic       HIGH_LINE_RESET     = 1'h0;

  // Comparator and status inputs, each high when the condition holds
  typedef struct packed {
    logic supply_above_inhibit;
    logic supply_above_start;
    logic supply_above_stop;
    logic supply_above_standby;
    logic supply_above_ovp;
    logic line_above_bo_start;
    logic line_above_bo_stop;
    logic line_above_drive_disable;
    logic line_above_line_select;
    logic hv_pin_above_ps;
    logic line_pin_above_ps;
    logic line_absent;
    logic power_saving_mode;
    logic fault_latching;
    logic fault_auto;
  } cmp_t;

  // Startup source and supply controls
  typedef struct packed {
    logic hv_src_on;
    logic line_src_on;
    logic src_full;
    logic sink_on;
    logic low_current;
  } supply_ctl_t;

  // Converter stage controls
  typedef struct packed {
    logic pfc_enable;
    logic flyback_enable;
    logic divider_connect;
    logic latched;
  } stage_ctl_t;

  // Line range outputs
  typedef struct packed {
    logic       high_line;
    logic       ff_gain_high;
    logic [1:0] ontime_div;
  } range_ctl_t;

  typedef enum logic [6:0] {
    ST_CHARGE = 7'h01,
    ST_RUN    = 7'h02,
    ST_SAVE   = 7'h04,
    ST_SINK   = 7'h08,
    ST_DISCH  = 7'h10,
    ST_LOWCUR = 7'h20,
    ST_LATCH  = 7'h40
  } state_t;

endpackage
`default_nettype wire

/* logic/level_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  // Levels in and out
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // Two flip-flop synchroniser
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      stage1 <= '0;
      o_sync <= '0;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule // level_sync
`default_nettype wire

/* verif/mains_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mains_supply_model #(
  parameter int INHIBIT = 50
) (
  // Clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_srst,
  // Line conditions and auxiliary winding mode
  input  wire supervisor_pkg::cmp_t        i_line,
  input  wire logic [1:0]                  i_aux,
  // Device controls
  input  wire supervisor_pkg::supply_ctl_t i_supply,
  input  wire supervisor_pkg::stage_ctl_t  i_stage,
  // Comparators and supply in tenths of a volt
  output var  supervisor_pkg::cmp_t        o_cmp,
  output var  int                          o_vcc
);
  int nxt;
  int gain;
  int filt;

  // Supply capacitor with bias drain, sources, sink and aux winding
  always_comb
  begin
    gain = 0;
    if ((i_supply.hv_src_on || i_supply.line_src_on) && o_vcc < 200)
      gain = i_supply.src_full ? 10 : 3;
    if (i_line.line_absent && gain > filt)
      gain = filt;
    nxt = o_vcc + gain - 1 - (i_supply.sink_on ? 10 : 0);
    if (i_stage.flyback_enable)
      nxt = nxt + ((i_aux == 2'h2) ? 4 : int'(i_aux));
    o_cmp = i_line;
    o_cmp.supply_above_inhibit = o_vcc > INHIBIT;
    o_cmp.supply_above_start = o_vcc >= 170;
    o_cmp.supply_above_stop = o_vcc > 88;
    o_cmp.supply_above_standby = o_vcc > 110;
    o_cmp.supply_above_ovp = o_vcc > 280;
  end

  // Filter capacitor holds limited charge once the line is gone
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_vcc <= 0;
      filt <= 120;
    end
    else
    begin
      o_vcc <= (nxt < 0) ? 0 : nxt;
      filt <= i_line.line_absent ? filt - gain : 120;
    end
  end
endmodule // mains_supply_model
`default_nettype wire

/* verif/supply_startup_line_supervisor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_startup_line_supervisor_tb;
  localparam int BO = 20;
  localparam int HV = 12, LS = 11, FULL = 10, SINK = 9, LOWC = 8, PFC = 7, FB = 6;
  localparam int DIV = 5, LAT = 4, HI = 3;
  logic                        i_clock;
  logic                        i_srst;
  supervisor_pkg::cmp_t        line;
  supervisor_pkg::cmp_t        cmp;
  logic [1:0]                  aux;
  supervisor_pkg::supply_ctl_t sup;
  supervisor_pkg::stage_ctl_t  stg;
  supervisor_pkg::range_ctl_t  rng;
  wire logic [12:0]            obs = {sup, stg, rng};
  int                          vcc;
  int                          n_mismatch;
  int                          tests_run;

  supply_startup_line_supervisor #(.BROWNOUT_CYC(BO), .LOW_TO_HIGH_CYC(10),
    .HIGH_TO_LOW_CYC(20)) dut (.i_clock(i_clock), .i_srst(i_srst), .i_cmp(cmp),
    .o_supply(sup), .o_stage(stg), .o_range(rng));
  mains_supply_model #(.INHIBIT(50)) far (.i_clock(i_clock), .i_srst(i_srst),
    .i_line(line), .i_aux(aux), .i_supply(sup), .i_stage(stg), .o_cmp(cmp), .o_vcc(vcc));

  initial
  begin
    i_clock = 1'h0;
    forever #25 i_clock = ~i_clock;
  end

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_bit(input int k, input logic v, input int lim);
    int i;
    i = 0;
    while (i < lim && obs[k] !== v)
    begin
      step(1);
      i++;
    end
    chk(obs[k], v, "wait");
    if (obs[k] !== v)
      complete_run();
  endtask

  task automatic do_reset();
    line = '0;
    aux = 2'h1;
    i_srst = 1'h1;
    step(3);
    i_srst = 1'h0;
    step(1);
    chk(obs[12:5], 8'hC0, "reset");
    chk(obs[HI], 1'h0, "range reset");
  endtask

  task automatic t_startup();
    line.line_above_bo_start = 1'h1;
    line.line_above_bo_stop = 1'h1;
    line.line_above_drive_disable = 1'h1;
    line.hv_pin_above_ps = 1'h1;
    step(10);
    chk({obs[FULL], obs[HV], obs[LS]}, 3'h3, "reduced");
    wait_bit(FULL, 1'h1, 60);
    chk(vcc > 50, 1'h1, "inhibit");
    wait_bit(FB, 1'h1, 60);
    chk(vcc >= 170, 1'h1, "start");
    chk({obs[HV], obs[LS], obs[PFC], obs[DIV]}, 4'h3, "run");
  endtask

  task automatic t_stop();
    aux = 2'h0;
    wait_bit(HV, 1'h1, 150);
    chk({obs[LS], obs[FB], obs[PFC], vcc <= 88}, 4'h9, "stop");
    aux = 2'h1;
    wait_bit(FB, 1'h1, 60);
    chk(vcc >= 170, 1'h1, "restart");
  endtask

  task automatic t_range();
    line.line_above_line_select = 1'h1;
    step(8);
    chk(obs[HI], 1'h0, "early");
    wait_bit(HI, 1'h1, 12);
    chk(obs[2:0], {1'h1, supervisor_pkg::ONTIME_DIV_HIGH}, "high");
    line.line_above_line_select = 1'h0;
    step(14);
    line.line_above_line_select = 1'h1;
    step(3);
    line.line_above_line_select = 1'h0;
    step(14);
    chk(obs[HI], 1'h1, "held");
    wait_bit(HI, 1'h0, 16);
    chk(obs[2:0], {1'h0, supervisor_pkg::ONTIME_DIV_LOW}, "low");
    line.line_above_line_select = 1'h1;
    step(20);
    chk(obs[HI], 1'h0, "inhibit");
    line.line_above_bo_stop = 1'h0;
    step(3);
    line.line_above_bo_stop = 1'h1;
    wait_bit(HI, 1'h1, 20);
  endtask

  task automatic t_brownout();
    line.line_above_bo_start = 1'h0;
    line.line_above_bo_stop = 1'h0;
    line.line_above_drive_disable = 1'h0;
    step(BO - 4);
    chk(obs[FB], 1'h1, "timer");
    line.line_above_drive_disable = 1'h1;
    step(12);
    chk(obs[FB], 1'h1, "line high");
    line.line_above_drive_disable = 1'h0;
    wait_bit(FB, 1'h0, 6);
    chk(obs[PFC], 1'h0, "pfc off");
    line.line_above_bo_start = 1'h1;
    line.line_above_bo_stop = 1'h1;
    line.line_above_drive_disable = 1'h1;
    wait_bit(HV, 1'h1, 8);
    wait_bit(FB, 1'h1, 40);
  endtask

  task automatic t_psm();
    line.line_pin_above_ps = 1'h0;
    line.power_saving_mode = 1'h1;
    aux = 2'h0;
    wait_bit(HV, 1'h1, 150);
    chk({obs[LS], vcc <= 110}, 2'h1, "save on");
    wait_bit(HV, 1'h0, 20);
    chk(vcc > 110, 1'h1, "save off");
    line.power_saving_mode = 1'h0;
    aux = 2'h1;
    wait_bit(LS, 1'h1, 8);
    chk(obs[HV], 1'h1, "both");
    wait_bit(FB, 1'h1, 40);
  endtask

  task automatic t_fault();
    line.fault_auto = 1'h1;
    wait_bit(FB, 1'h0, 8);
    step(10);
    chk(obs[FB], 1'h0, "held off");
    line.fault_auto = 1'h0;
    wait_bit(FB, 1'h1, 60);
  endtask

  task automatic t_ovp();
    aux = 2'h2;
    wait_bit(LAT, 1'h1, 60);
    chk({obs[FB], obs[PFC], vcc > 280}, 3'h1, "latch");
    aux = 2'h1;
    step(20);
    chk({obs[LAT], obs[FB]}, 2'h2, "latched");
  endtask

  task automatic t_absent();
    line = '0;
    line.line_absent = 1'h1;
    wait_bit(SINK, 1'h1, 8);
    chk({obs[FB], obs[PFC], obs[DIV]}, 3'h0, "absent");
    wait_bit(HV, 1'h1, 30);
    chk({obs[LS], obs[SINK], vcc <= 88}, 3'h5, "discharge");
    wait_bit(LOWC, 1'h1, 150);
    chk(obs[HV] | obs[LS], 1'h0, "low current");
  endtask

  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    do_reset();
    t_startup();
    t_stop();
    t_range();
    t_brownout();
    t_psm();
    t_fault();
    t_ovp();
    do_reset();
    t_startup();
    t_absent();
    complete_run();
  end
endmodule // supply_startup_line_supervisor_tb
`default_nettype wire
